//--- flash_guard_defs.svh
// offsets, field positions, reset values and key codes of the flash guard
`ifndef FLASH_GUARD_DEFS_SVH
`define FLASH_GUARD_DEFS_SVH

`define PSC_OFFSET          8'h8F
`define FKEY_OFFSET         8'hB7
`define RSTCAUSE_OFFSET     8'hEF
`define PSC_WE_BIT          0
`define PSC_EE_BIT          1
`define PSC_RESET           8'h00
`define FKEY_RESET          8'h00
`define KEY_FIRST_CODE      8'hA5
`define KEY_SECOND_CODE     8'hF1
`define LOCK_BYTE_ERASED    8'hFF
`define FLASH_SIZE_BYTES    32768
`define FLASH_PAGE_BYTES    512
`define LOCK_BYTE_ADDR      15'h7DFF
`define RESERVED_BASE       15'h7E00

`endif

//--- flash_guard_pkg.sv
// types shared by the flash guard modules
package flash_guard_pkg;

    typedef enum logic [1:0] {
        CPU_CODE_MOVE_RD = 2'b00,
        CPU_EXT_MOVE_RD  = 2'b01,
        CPU_EXT_MOVE_WR  = 2'b10
    } cpu_kind_t;

    typedef enum logic [1:0] {
        DBG_READ       = 2'b00,
        DBG_WRITE      = 2'b01,
        DBG_ERASE      = 2'b10,
        DBG_FULL_ERASE = 2'b11
    } dbg_op_t;

    typedef enum logic [1:0] {
        FCMD_READ       = 2'b00,
        FCMD_WRITE      = 2'b01,
        FCMD_ERASE      = 2'b10,
        FCMD_FULL_ERASE = 2'b11
    } flash_cmd_t;

    typedef enum logic [1:0] {
        KEY_LOCKED   = 2'b00,
        KEY_FIRST    = 2'b01,
        KEY_OPEN     = 2'b10,
        KEY_DISABLED = 2'b11
    } key_state_t;

endpackage : flash_guard_pkg

//--- flash_page_class.sv
// classifies one flash address against the lock byte and the reserved area
`timescale 1ns/100ps
`default_nettype none
`include "flash_guard_defs.svh"

module flash_page_class #(
    parameter int ADDR_W    = 15,
    parameter int PAGE_BITS = 9
) (
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        lock_byte,
    output logic                   is_reserved,
    output logic                   is_lock_page,
    output logic                   is_lock_byte,
    output logic                   is_locked_page
);
    localparam logic [ADDR_W-1:0] LOCK_ADDR = ADDR_W'(`LOCK_BYTE_ADDR);
    localparam logic [ADDR_W-1:0] RSV_BASE  = ADDR_W'(`RESERVED_BASE);

    logic [7:0] page_count;
    logic [7:0] page_index;

    // page count is the inverse of the lock byte
    assign page_count     = ~lock_byte;
    assign page_index     = 8'(addr[ADDR_W-1:PAGE_BITS]);
    assign is_reserved    = (addr >= RSV_BASE);
    assign is_lock_page   = (addr[ADDR_W-1:PAGE_BITS] == LOCK_ADDR[ADDR_W-1:PAGE_BITS]);
    assign is_lock_byte   = (addr == LOCK_ADDR);
    assign is_locked_page = (page_index < page_count) && !is_lock_page && !is_reserved;

endmodule : flash_page_class
`default_nettype wire

//--- flash_write_guard.sv
// flash write guard and page lock: register port, key sequence and access arbitration
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "flash_guard_defs.svh"

// Functional notes
// - external-move reads always go to data RAM; code-move reads go to flash.
// - flash modification needs write enable; erase needs write and erase enable.
// - lock byte at end of user flash locks its inverse count of pages from zero.
// - lock-byte page is locked whenever any lock-byte bit is zero.
// - prohibited debug-port operations are silently ignored, no reset.
// - firmware on unlocked page touching locked pages or lock data gets error reset.
// - firmware on a locked page may access locked pages and the lock byte.
// - firmware erase of lock-byte page resets; debug erases it only when unlocked.
// - while locked, only a debug full erase unlocks; it clears every page.
// - changing a written lock byte is refused; firmware attempts get error reset.
// - a newly written lock byte takes effect only after the next reset.
// - reserved area is blocked: debug ignored, firmware gets error reset.
// - firmware modification with supply monitor or its reset source off resets.
// - interrupts are held while a flash write or erase is in progress.
// - with both enables set an external-move write erases the addressed page.
// - write enable steers external-move writes to flash, else to data RAM.
// - upper six control bits read zero; erase enable bit 1, write enable bit 0.
// - two key codes in order unlock; wrong order or early operation disables.
// - key register reads lock state in bits 1-0; unlock clears after each firmware write or erase, not after debug operations.
module flash_write_guard
    import flash_guard_pkg::*;
#(
    parameter int ADDR_W    = 15,
    parameter int PAGE_BITS = 9
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    input  wire logic              cpu_req,
    input  wire logic [1:0]        cpu_kind,
    input  wire logic [15:0]       cpu_addr,
    input  wire logic [7:0]        cpu_wdata,
    input  wire logic [15:0]       cpu_exec_addr,
    output logic                   cpu_ready,
    input  wire logic              dbg_req,
    input  wire logic [1:0]        dbg_op,
    input  wire logic [ADDR_W-1:0] dbg_addr,
    input  wire logic [7:0]        dbg_wdata,
    output logic                   dbg_ready,
    output logic                   dbg_accepted,
    output logic                   dbg_ignored,
    input  wire logic              supply_mon_en,
    input  wire logic              supply_mon_reset_src,
    input  wire logic [7:0]        lock_byte_in,
    input  wire logic              flash_done,
    output logic                   flash_req,
    output logic      [1:0]        flash_cmd,
    output logic      [ADDR_W-1:0] flash_addr,
    output logic      [7:0]        flash_wdata,
    output logic                   ram_req,
    output logic                   ram_we,
    output logic      [15:0]       ram_addr,
    output logic      [7:0]        ram_wdata,
    output logic                   flash_error_reset,
    output logic                   flash_error_flag,
    output logic                   irq_hold,
    output logic                   flash_busy
);
    initial begin
        if (ADDR_W <= PAGE_BITS || ADDR_W > 16 || (ADDR_W - PAGE_BITS) > 8) begin
            $error("flash_write_guard: unsupported address or page width");
        end
        if ((1 << ADDR_W) != `FLASH_SIZE_BYTES || (1 << PAGE_BITS) != `FLASH_PAGE_BYTES) begin
            $error("flash_write_guard: widths do not match flash geometry");
        end
    end

    logic             write_en_reg;
    logic             erase_en_reg;
    key_state_t       key_reg;
    key_state_t       key_next;
    logic [7:0]       lock_reg;
    logic             lock_loaded_reg;
    logic             busy_reg;
    logic             busy_fw_reg;
    logic             err_flag_reg;
    logic [7:0]       rdata_reg;

    logic             tgt_rsv;
    logic             tgt_lpage;
    logic             tgt_lbyte;
    logic             tgt_locked;
    logic             exe_rsv;
    logic             exe_lpage;
    logic             exe_lbyte;
    logic             exe_locked;
    logic             dbg_rsv;
    logic             dbg_lpage;
    logic             dbg_lbyte;
    logic             dbg_locked;

    logic             any_locked;
    logic             lock_written;
    logic             supply_ok;
    logic             exec_from_locked;
    logic             cpu_take;
    logic             dbg_take;
    logic             c_flash_rd;
    logic             c_modify;
    logic             c_erase;
    logic             c_ram;
    logic             c_lock_hit;
    logic             c_fault;
    logic             c_key_bad;
    logic             c_issue_mod;
    logic             d_modify;
    logic             d_block;
    logic [ADDR_W-1:0] cpu_faddr;

    assign cpu_faddr = cpu_addr[ADDR_W-1:0];

    flash_page_class #(.ADDR_W(ADDR_W), .PAGE_BITS(PAGE_BITS)) u_cls_target (
        .addr           (cpu_faddr),
        .lock_byte      (lock_reg),
        .is_reserved    (tgt_rsv),
        .is_lock_page   (tgt_lpage),
        .is_lock_byte   (tgt_lbyte),
        .is_locked_page (tgt_locked)
    );

    flash_page_class #(.ADDR_W(ADDR_W), .PAGE_BITS(PAGE_BITS)) u_cls_exec (
        .addr           (cpu_exec_addr[ADDR_W-1:0]),
        .lock_byte      (lock_reg),
        .is_reserved    (exe_rsv),
        .is_lock_page   (exe_lpage),
        .is_lock_byte   (exe_lbyte),
        .is_locked_page (exe_locked)
    );

    flash_page_class #(.ADDR_W(ADDR_W), .PAGE_BITS(PAGE_BITS)) u_cls_debug (
        .addr           (dbg_addr),
        .lock_byte      (lock_reg),
        .is_reserved    (dbg_rsv),
        .is_lock_page   (dbg_lpage),
        .is_lock_byte   (dbg_lbyte),
        .is_locked_page (dbg_locked)
    );

    // lock state and access classification
    assign any_locked       = (lock_reg != `LOCK_BYTE_ERASED);
    assign lock_written     = (lock_byte_in != `LOCK_BYTE_ERASED);
    assign supply_ok        = supply_mon_en && supply_mon_reset_src;
    assign exec_from_locked = exe_locked || (exe_lpage && any_locked);

    // cpu has priority; both wait while an operation runs or the lock byte loads
    assign cpu_ready = lock_loaded_reg && !busy_reg;
    assign dbg_ready = lock_loaded_reg && !busy_reg && !cpu_req;
    assign cpu_take  = cpu_req && cpu_ready;
    assign dbg_take  = dbg_req && dbg_ready;

    assign c_flash_rd = (cpu_kind == CPU_CODE_MOVE_RD);
    assign c_modify   = (cpu_kind == CPU_EXT_MOVE_WR) && write_en_reg;
    assign c_erase    = c_modify && erase_en_reg;
    assign c_ram      = (cpu_kind == CPU_EXT_MOVE_RD) || ((cpu_kind == CPU_EXT_MOVE_WR) && !write_en_reg);

    // locked-page or lock-data access by code running from an unlocked page
    assign c_lock_hit = tgt_locked || (tgt_lpage && any_locked);

    always_comb begin
        c_fault = 1'b0;
        if (c_flash_rd || c_modify) begin
            if (tgt_rsv) begin
                c_fault = 1'b1;
            end
            if (c_lock_hit && !exec_from_locked) begin
                c_fault = 1'b1;
            end
        end
        if (c_erase && tgt_lpage) begin
            c_fault = 1'b1;
        end
        if (c_modify && !c_erase && tgt_lbyte && lock_written) begin
            c_fault = 1'b1;
        end
        if (c_modify && !supply_ok) begin
            c_fault = 1'b1;
        end
    end

    // an operation without a full key sequence is dropped and disables further ones
    assign c_key_bad   = c_modify && !c_fault && (key_reg != KEY_OPEN);
    assign c_issue_mod = c_modify && !c_fault && (key_reg == KEY_OPEN);

    assign d_modify = (dbg_op == DBG_WRITE) || (dbg_op == DBG_ERASE) || (dbg_op == DBG_FULL_ERASE);

    always_comb begin
        d_block = 1'b0;
        if (dbg_op != DBG_FULL_ERASE) begin
            if (dbg_rsv || dbg_locked) begin
                d_block = 1'b1;
            end
            if (dbg_lpage && any_locked) begin
                d_block = 1'b1;
            end
            if (dbg_op == DBG_WRITE && dbg_lbyte && lock_written) begin
                d_block = 1'b1;
            end
        end
    end

    // control register: only the two enable bits hold state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            write_en_reg <= 1'(`PSC_RESET >> `PSC_WE_BIT);
            erase_en_reg <= 1'(`PSC_RESET >> `PSC_EE_BIT);
        end else if (reg_wr && reg_addr == `PSC_OFFSET) begin
            write_en_reg <= reg_wdata[`PSC_WE_BIT];
            erase_en_reg <= reg_wdata[`PSC_EE_BIT];
        end
    end

    // key sequence
    always_comb begin
        key_next = key_reg;
        if (reg_wr && reg_addr == `FKEY_OFFSET) begin
            unique case (key_reg)
                KEY_LOCKED:   key_next = (reg_wdata == `KEY_FIRST_CODE) ? KEY_FIRST : KEY_DISABLED;
                KEY_FIRST:    key_next = (reg_wdata == `KEY_SECOND_CODE) ? KEY_OPEN : KEY_DISABLED;
                KEY_OPEN:     key_next = KEY_DISABLED;
                KEY_DISABLED: key_next = KEY_DISABLED;
            endcase
        end
        if (cpu_take && c_key_bad) begin
            key_next = KEY_DISABLED;
        end else if (busy_fw_reg && flash_done && key_next == KEY_OPEN) begin
            key_next = KEY_LOCKED;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_reg <= KEY_LOCKED;
        end else begin
            key_reg <= key_next;
        end
    end

    // lock byte is sampled once after reset; later writes to it wait for a reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_reg        <= `LOCK_BYTE_ERASED;
            lock_loaded_reg <= 1'b0;
        end else if (!lock_loaded_reg) begin
            lock_reg        <= lock_byte_in;
            lock_loaded_reg <= 1'b1;
        end else if (dbg_take && dbg_op == DBG_FULL_ERASE) begin
            lock_reg <= `LOCK_BYTE_ERASED;
        end
    end

    // busy spans a write or erase until the flash engine reports done
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg    <= 1'b0;
            busy_fw_reg <= 1'b0;
        end else if (busy_reg) begin
            if (flash_done) begin
                busy_reg    <= 1'b0;
                busy_fw_reg <= 1'b0;
            end
        end else if (cpu_take && c_issue_mod) begin
            busy_reg    <= 1'b1;
            busy_fw_reg <= 1'b1;
        end else if (dbg_take && d_modify && !d_block) begin
            busy_reg <= 1'b1;
        end
    end

    // holding interrupts keeps them pending; the cpu services them after completion
    assign irq_hold   = busy_reg;
    assign flash_busy = busy_reg;

    // flash command issue
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_req   <= 1'b0;
            flash_cmd   <= FCMD_READ;
            flash_addr  <= '0;
            flash_wdata <= 8'h00;
        end else begin
            flash_req <= 1'b0;
            if (cpu_take && ((c_flash_rd && !c_fault) || c_issue_mod)) begin
                flash_req   <= 1'b1;
                flash_cmd   <= c_erase ? FCMD_ERASE : (c_modify ? FCMD_WRITE : FCMD_READ);
                flash_addr  <= cpu_faddr;
                flash_wdata <= cpu_wdata;
            end else if (dbg_take && !d_block) begin
                flash_req   <= 1'b1;
                flash_cmd   <= flash_cmd_t'(dbg_op);
                flash_addr  <= dbg_addr;
                flash_wdata <= dbg_wdata;
            end
        end
    end

    // data RAM path for external moves not aimed at flash
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ram_req   <= 1'b0;
            ram_we    <= 1'b0;
            ram_addr  <= 16'h0000;
            ram_wdata <= 8'h00;
        end else begin
            ram_req <= cpu_take && c_ram;
            if (cpu_take && c_ram) begin
                ram_we    <= (cpu_kind == CPU_EXT_MOVE_WR);
                ram_addr  <= cpu_addr;
                ram_wdata <= cpu_wdata;
            end
        end
    end

    // debug answers: a refused request is only reported, never a reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dbg_accepted <= 1'b0;
            dbg_ignored  <= 1'b0;
        end else begin
            dbg_accepted <= dbg_take && !d_block;
            dbg_ignored  <= dbg_take && d_block;
        end
    end

    // error reset pulse and its sticky cause flag
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_error_reset <= 1'b0;
            err_flag_reg      <= 1'b0;
        end else begin
            flash_error_reset <= cpu_take && c_fault;
            if (cpu_take && c_fault) begin
                err_flag_reg <= 1'b1;
            end
        end
    end

    assign flash_error_flag = err_flag_reg;

    // register read, data stand for one cycle only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `PSC_OFFSET:      rdata_reg <= {6'b00_0000, erase_en_reg, write_en_reg};
                `FKEY_OFFSET:     rdata_reg <= {6'b00_0000, key_reg};
                `RSTCAUSE_OFFSET: rdata_reg <= {7'b000_0000, err_flag_reg};
                default:          rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule : flash_write_guard
`default_nettype wire

//--- flash_write_guard_chk.sv
// concurrent checks on the ports of the flash write guard
`timescale 1ns/100ps
`default_nettype none

module flash_write_guard_chk (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        cpu_req,
    input wire logic [1:0]  cpu_kind,
    input wire logic        cpu_ready,
    input wire logic        dbg_req,
    input wire logic [1:0]  dbg_op,
    input wire logic [14:0] dbg_addr,
    input wire logic        dbg_ready,
    input wire logic        dbg_accepted,
    input wire logic        dbg_ignored,
    input wire logic        supply_mon_en,
    input wire logic        supply_mon_reset_src,
    input wire logic        flash_req,
    input wire logic [1:0]  flash_cmd,
    input wire logic        ram_req,
    input wire logic        ram_we,
    input wire logic        flash_error_reset,
    input wire logic        flash_error_flag,
    input wire logic        irq_hold,
    input wire logic        flash_busy
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // shadow of the enable bits
    logic [1:0] en_reg;
    wire        take_wr = cpu_req && cpu_ready && cpu_kind == 2'b10;
    wire        take_dbg = dbg_req && dbg_ready;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_reg <= 2'b00;
        end else if (reg_wr && reg_addr == 8'h8F) begin
            en_reg <= reg_wdata[1:0];
        end
    end

    property p_ctrl_read;
        $past(reg_rd) && $past(reg_addr) == 8'h8F |-> reg_rdata == {6'h00, $past(en_reg)};
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl read");
    property p_key_wrong;
        reg_wr && reg_addr == 8'hB7 && reg_wdata != 8'hA5 && reg_wdata != 8'hF1
            ##2 reg_rd && reg_addr == 8'hB7 |=> reg_rdata[1:0] == 2'b11;
    endproperty
    a_key_wrong: assert property (p_key_wrong) else $error("bad key kept");
    property p_ext_rd;
        cpu_req && cpu_ready && cpu_kind == 2'b01 |=> ram_req && !ram_we && !flash_req;
    endproperty
    a_ext_rd: assert property (p_ext_rd) else $error("ext read not ram");
    property p_ram_wr;
        take_wr && !en_reg[0] |=> ram_req && ram_we && !flash_req;
    endproperty
    a_ram_wr: assert property (p_ram_wr) else $error("write not ram");
    property p_write;
        take_wr && en_reg == 2'b01 |=> !ram_req && (!flash_req || flash_cmd == 2'b01);
    endproperty
    a_write: assert property (p_write) else $error("write misrouted");
    property p_erase;
        take_wr && en_reg == 2'b11 |=> !ram_req && (!flash_req || flash_cmd == 2'b10);
    endproperty
    a_erase: assert property (p_erase) else $error("erase misrouted");
    property p_supply;
        take_wr && en_reg[0] && !(supply_mon_en && supply_mon_reset_src) |=> flash_error_reset;
    endproperty
    a_supply: assert property (p_supply) else $error("no supply reset");
    property p_dbg_quiet;
        dbg_ignored |-> !flash_error_reset && !flash_req && !dbg_accepted;
    endproperty
    a_dbg_quiet: assert property (p_dbg_quiet) else $error("ignored op acted");
    property p_dbg_reserved;
        take_dbg && dbg_addr >= 15'h7E00 && dbg_op != 2'b11 |=> dbg_ignored && !flash_req;
    endproperty
    a_dbg_reserved: assert property (p_dbg_reserved) else $error("reserved passed");
    property p_full_erase;
        take_dbg && dbg_op == 2'b11 |=> dbg_accepted && flash_req && flash_cmd == 2'b11;
    endproperty
    a_full_erase: assert property (p_full_erase) else $error("full erase refused");
    property p_flag;
        flash_error_reset |=> flash_error_flag [*2];
    endproperty
    a_flag: assert property (p_flag) else $error("flag dropped");
    property p_busy;
        flash_busy |-> irq_hold && !cpu_ready && !dbg_ready;
    endproperty
    a_busy: assert property (p_busy) else $error("no irq hold");

    c_erase: cover property (take_wr && en_reg == 2'b11);
    c_ignored: cover property (dbg_ignored);
    c_fault: cover property (flash_error_reset);
endmodule : flash_write_guard_chk

bind flash_write_guard flash_write_guard_chk flash_write_guard_chk_inst (.*);

`default_nettype wire

//--- flash_array_model.sv
// behavioural flash array and timing engine behind the guard
`timescale 1ns/100ps
`default_nettype none

module flash_array_model #(
    parameter logic [7:0] INIT_LOCK = 8'hFF
) (
    input  wire logic        ref_clk,
    input  wire logic        flash_req,
    input  wire logic [1:0]  flash_cmd,
    input  wire logic [14:0] flash_addr,
    input  wire logic [7:0]  flash_wdata,
    output logic             flash_done,
    output logic      [7:0]  lock_byte_in
);
    int cnt = 0;
    bit slow = 1'b0;

    initial flash_done = 1'b0;
    initial lock_byte_in = INIT_LOCK;

    // short and long ops alternate; content survives reset
    always @(posedge ref_clk) begin
        flash_done <= 1'b0;
        if (flash_req && flash_cmd != 2'b00) begin
            cnt <= slow ? 12 : 2;
            slow <= !slow;
            if (flash_cmd == 2'b11 || (flash_cmd == 2'b10 && flash_addr[14:9] == 6'h3E)) begin
                lock_byte_in <= 8'hFF;
            end else if (flash_cmd == 2'b01 && flash_addr == 15'h7DFF) begin
                lock_byte_in <= lock_byte_in & flash_wdata; // programming only clears bits
            end
        end else if (cnt == 1) begin
            cnt <= 0;
            flash_done <= 1'b1;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule : flash_array_model

`default_nettype wire

//--- flash_write_guard_test.sv
// self-checking bench for the flash write guard
`timescale 1ns/100ps
`default_nettype none

module flash_write_guard_test
    import flash_guard_pkg::*;
;
    localparam logic [7:0] ERR = 8'h80, FL = 8'h40, RAM = 8'h20, ACC = 8'h10, IGN = 8'h08;
    logic        ref_clk = 1'b0, rst_n = 1'b0;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, cpu_wdata, dbg_wdata, lock_byte_in, flash_wdata, ram_wdata;
    logic        reg_wr, reg_rd, cpu_req, cpu_ready, dbg_req, dbg_ready, dbg_accepted, dbg_ignored;
    logic        supply_mon_en, supply_mon_reset_src, flash_done, flash_req, ram_req, ram_we;
    logic        flash_error_reset, flash_error_flag, irq_hold, flash_busy;
    logic [1:0]  cpu_kind, dbg_op, flash_cmd;
    logic [15:0] cpu_addr, cpu_exec_addr, ram_addr;
    logic [14:0] dbg_addr, flash_addr;
    int          n_mismatch = 0, compares = 0;

    flash_write_guard flash_write_guard_inst (.*);
    flash_array_model flash_array_model_inst (.*);

    always #12.5 ref_clk = ~ref_clk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    // a read checks the data of the next cycle
    task automatic acc(input bit w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= w;
        reg_rd    <= !w;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        @(negedge ref_clk);
        if (!w) chk(reg_rdata, d);
    endtask : acc

    // cpu or debug access; outcome: err fl ram acc ign we cmd
    task automatic req(input bit dbg, input logic [1:0] k, input logic [15:0] a,
                       input logic [15:0] ex, input logic [7:0] exp);
        for (int i = 0; i < 40 && (dbg ? dbg_ready : cpu_ready) !== 1'b1; i++) @(negedge ref_clk);
        @(posedge ref_clk);
        cpu_req       <= !dbg;
        dbg_req       <= dbg;
        cpu_kind      <= k;
        dbg_op        <= k;
        cpu_addr      <= a;
        dbg_addr      <= a[14:0];
        cpu_exec_addr <= ex;
        @(posedge ref_clk);
        cpu_req       <= 1'b0;
        dbg_req       <= 1'b0;
        @(negedge ref_clk);
        chk({flash_error_reset, flash_req, ram_req, dbg_accepted, dbg_ignored, ram_req & ram_we,
             flash_req ? flash_cmd : 2'b00}, exp);
    endtask : req

    task automatic unlock();
        acc(1, 8'hB7, 8'hA5);
        acc(0, 8'hB7, 8'h01);
        acc(1, 8'hB7, 8'hF1);
        acc(0, 8'hB7, 8'h02);
    endtask : unlock

    task automatic idle();
        for (int i = 0; i < 40 && flash_busy !== 1'b0; i++) @(negedge ref_clk);
    endtask : idle

    task automatic do_reset();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
    endtask : do_reset

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // run is about 160 cycles
    initial begin
        #50us;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        {reg_wr, reg_rd, cpu_req, dbg_req} = 4'h0;
        {reg_addr, reg_wdata, cpu_kind, cpu_addr, cpu_wdata, cpu_exec_addr, dbg_op, dbg_addr, dbg_wdata} = '0;
        {supply_mon_en, supply_mon_reset_src} = 2'b11;
        do_reset();
        acc(0, 8'h8F, 8'h00);
        acc(0, 8'hB7, 8'h00);
        acc(0, 8'h10, 8'h00);
        acc(1, 8'h8F, 8'hFF);
        acc(0, 8'h8F, 8'h03);
        acc(1, 8'h8F, 8'h00);
        req(0, CPU_EXT_MOVE_RD, 16'h0200, 16'h0600, RAM);
        req(0, CPU_EXT_MOVE_WR, 16'h0200, 16'h0600, RAM | 8'h04);
        req(0, CPU_CODE_MOVE_RD, 16'h0200, 16'h0600, FL);
        unlock();
        acc(1, 8'h8F, 8'h01);
        req(0, CPU_EXT_MOVE_WR, 16'h0A10, 16'h0600, FL | 8'h01);
        chk({7'h00, irq_hold}, 8'h01);
        idle();
        acc(0, 8'hB7, 8'h00);
        unlock();
        acc(1, 8'h8F, 8'h03);
        req(0, CPU_EXT_MOVE_WR, 16'h0A10, 16'h0600, FL | 8'h02);
        @(posedge ref_clk) supply_mon_en <= 1'b0;
        req(0, CPU_EXT_MOVE_WR, 16'h0A10, 16'h0600, ERR);
        acc(0, 8'hEF, 8'h01);
        @(posedge ref_clk) supply_mon_en <= 1'b1;
        req(0, CPU_EXT_MOVE_WR, 16'h7C00, 16'h0600, ERR);
        req(0, CPU_CODE_MOVE_RD, 16'h7E00, 16'h0600, ERR);
        req(1, DBG_READ, 16'h7F00, 16'h0000, IGN);
        req(1, DBG_ERASE, 16'h7C00, 16'h0000, ACC | FL | 8'h02);
        req(0, CPU_EXT_MOVE_WR, 16'h0A10, 16'h0600, 8'h00);
        acc(0, 8'hB7, 8'h03);
        // written lock byte waits for reset
        do_reset();
        unlock();
        acc(1, 8'h8F, 8'h01);
        @(posedge ref_clk) cpu_wdata <= 8'hFD;
        req(0, CPU_EXT_MOVE_WR, 16'h7DFF, 16'h0600, FL | 8'h01);
        req(1, DBG_READ, 16'h0000, 16'h0000, ACC | FL);
        req(0, CPU_EXT_MOVE_WR, 16'h7DFF, 16'h0600, ERR);
        do_reset();
        req(1, DBG_READ, 16'h0200, 16'h0000, IGN);
        req(1, DBG_READ, 16'h0400, 16'h0000, ACC | FL);
        req(1, DBG_READ, 16'h7DFF, 16'h0000, IGN);
        req(1, DBG_WRITE, 16'h7DFF, 16'h0000, IGN);
        req(0, CPU_CODE_MOVE_RD, 16'h0000, 16'h0600, ERR);
        req(0, CPU_CODE_MOVE_RD, 16'h7DFF, 16'h0600, ERR);
        req(0, CPU_CODE_MOVE_RD, 16'h0200, 16'h0000, FL);
        req(0, CPU_CODE_MOVE_RD, 16'h7DFF, 16'h0200, FL);
        acc(1, 8'h8F, 8'h03);
        req(0, CPU_EXT_MOVE_WR, 16'h7C00, 16'h0000, ERR);
        req(1, DBG_ERASE, 16'h7C00, 16'h0000, IGN);
        req(1, DBG_FULL_ERASE, 16'h0000, 16'h0000, ACC | FL | 8'h03);
        req(1, DBG_READ, 16'h0000, 16'h0000, ACC | FL);
        acc(1, 8'hB7, 8'h5A);
        acc(0, 8'hB7, 8'h03);
        print_verdict();
    end
endmodule : flash_write_guard_test

`default_nettype wire
